// ### verilog/cal_seq_pkg.sv
// shared constants and types of the calibration sequencer
`default_nettype none
package cal_seq_pkg;
  // ==========================================
  // phase timing in master clock cycles, from the durations at the reference rate
  localparam int unsigned REF_CLK_KHZ = 6000;
  localparam int unsigned T_FULL_US = 41_700;
  localparam int unsigned T_GAIN_OFFSET_US = 9_260;
  localparam int unsigned T_SINGLE_US = 4_630;
  localparam int unsigned FULL_CYC = T_FULL_US * REF_CLK_KHZ / 1000;
  localparam int unsigned SINGLE_CYC = T_SINGLE_US * REF_CLK_KHZ / 1000;
  localparam int unsigned DAC_CYC = FULL_CYC - T_GAIN_OFFSET_US * REF_CLK_KHZ / 1000;
  localparam int unsigned CNT_W = 22;
  // ==========================================
  // trim range, in codes of a 14-bit full scale
  localparam int unsigned FULL_SCALE_CODES = 16384;
  localparam int unsigned OFFSET_RANGE_PPM = 37500;
  localparam int unsigned GAIN_RANGE_PPM = 18750;
  localparam int unsigned OFFSET_LIM = OFFSET_RANGE_PPM * FULL_SCALE_CODES / 1_000_000;
  localparam int unsigned GAIN_LIM = GAIN_RANGE_PPM * FULL_SCALE_CODES / 1_000_000;
  localparam int unsigned TRIM_W = 12;
  localparam int unsigned ERR_W = 16;
  // ==========================================
  // reset values
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [TRIM_W-1:0] TRIM_RST = 12'h000;
  // ==========================================
  // calibration types, in the order of the mode input
  typedef enum logic [2:0] {
    SELF_FULL, SELF_GAIN_OFFSET, SELF_OFFSET, SELF_GAIN,
    SYS_FULL, SYS_GAIN_OFFSET, SYS_OFFSET, SYS_GAIN
  } cal_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DAC, ST_GAIN, ST_OFFSET, ST_WAIT_TRIG} cal_state_t;
endpackage
`default_nettype wire

// ### verilog/sat_trim.sv
// saturating trim accumulator for one error term
`timescale 1ns/100ps
`default_nettype none
module sat_trim #(
  parameter int unsigned TW = 12,
  parameter int unsigned EW = 16,
  parameter int unsigned LIM = 614
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // correction step
  input wire logic apply,
  input wire logic signed [EW-1:0] err,
  // trim value
  output logic signed [TW-1:0] trim
);
  localparam int unsigned SW = EW + 1;
  typedef struct packed {
    logic signed [TW-1:0] trim;
  } trim_st_t;
  trim_st_t cur_ff;
  trim_st_t nxt_st;
  logic signed [SW-1:0] sum;
  // ==========================================
  // trim moves against the error, both signs, clamped at the range
  always_comb begin
    nxt_st = cur_ff;
    sum = SW'(cur_ff.trim) - SW'(err);
    if (apply) begin
      if (sum > $signed(SW'(LIM))) begin
        nxt_st.trim = TW'(LIM);
      end else if (sum < -$signed(SW'(LIM))) begin
        nxt_st.trim = -$signed(TW'(LIM));
      end else begin
        nxt_st.trim = TW'(sum);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '{trim: cal_seq_pkg::TRIM_RST};
    end else begin
      cur_ff <= nxt_st;
    end
  end
  assign trim = cur_ff.trim;
endmodule // sat_trim
`default_nettype wire

// ### verilog/cal_sequencer.sv
// calibration sequencer: pin and software starts, phase timing, busy, trims
// How it works
// - power-on: the first start after reset, pin rise or software pulse, runs a full self-calibration
// - power-on full calibration lasts the full duration in master clock cycles
// - four self types: full, gain plus offset, offset only, gain only
// - gain plus offset trims gain then offset, leaves the dac trim alone
// - offset phases move the zero-scale trim, gain phases the full-scale trim
// - pin falling edge resets the device, the next rising edge starts calibration
// - a software start pulse also begins the selected calibration once the power-on calibration has begun
// - busy rises the cycle after a software start, and on the third clock edge after a pin rise
// - busy stays high through self calibration and through each system phase; its length follows the type
// - trims saturate at the offset and gain range limits
// - trims correct errors of either sign
// - combined system calibration trims offset last, so offset wins
// - durations: full, offset plus gain, and single phases per type
// - full or combined system: busy drops after gain, trigger starts offset phase
`timescale 1ns/100ps
`default_nettype none
module cal_sequencer #(
  parameter int unsigned DAC_CYCLES = cal_seq_pkg::DAC_CYC,
  parameter int unsigned PHASE_CYCLES = cal_seq_pkg::SINGLE_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // pins from outside
  input wire logic CAL_N,
  input wire logic SAMPLE_TRIGGER,
  // control register side
  input wire logic TRIM_START_BIT,
  input wire logic [2:0] CAL_MODE,
  // measured errors from the converter
  input wire logic signed [cal_seq_pkg::ERR_W-1:0] OFFSET_ERR,
  input wire logic signed [cal_seq_pkg::ERR_W-1:0] GAIN_ERR,
  // status
  output logic BUSY,
  output logic CAL_RESET,
  output logic POWER_ON_CAL,
  // phase strobes to the analog trim
  output logic DAC_TRIM_ACTIVE,
  output logic GAIN_TRIM_ACTIVE,
  output logic OFFSET_TRIM_ACTIVE,
  // trim values
  output logic signed [cal_seq_pkg::TRIM_W-1:0] OFFSET_TRIM,
  output logic signed [cal_seq_pkg::TRIM_W-1:0] GAIN_TRIM
);
  localparam int unsigned CW = cal_seq_pkg::CNT_W;
  typedef struct packed {
    logic cal_s1;
    logic cal_s2;
    logic cal_prev;
    logic trg_s1;
    logic trg_s2;
    logic trg_prev;
    logic pwron_pending;
    logic pwron_run;
    logic busy;
    logic cal_reset;
    cal_seq_pkg::cal_mode_t mode;
    cal_seq_pkg::cal_state_t state;
    logic [CW-1:0] cnt;
  } seq_t;
  seq_t cur_ff;
  seq_t nxt_st;
  logic cal_fall;
  logic cal_rise;
  logic trg_rise;
  logic start;
  logic phase_end;
  logic apply_off;
  logic apply_gain;
  cal_seq_pkg::cal_mode_t sel_mode;
  // ==========================================
  // edge detection on synchronised pins
  assign cal_fall = cur_ff.cal_prev && !cur_ff.cal_s2;
  assign cal_rise = !cur_ff.cal_prev && cur_ff.cal_s2;
  assign trg_rise = !cur_ff.trg_prev && cur_ff.trg_s2;
  assign start = (cal_rise || TRIM_START_BIT) && !cal_fall;
  assign phase_end = (cur_ff.cnt == '0) && (cur_ff.state inside
    {cal_seq_pkg::ST_DAC, cal_seq_pkg::ST_GAIN, cal_seq_pkg::ST_OFFSET});
  assign sel_mode = cur_ff.pwron_pending ? cal_seq_pkg::SELF_FULL
                                         : cal_seq_pkg::cal_mode_t'(CAL_MODE);
  assign apply_off = phase_end && cur_ff.state == cal_seq_pkg::ST_OFFSET && !cal_fall;
  assign apply_gain = phase_end && cur_ff.state == cal_seq_pkg::ST_GAIN && !cal_fall;
  // ==========================================
  // sequencing
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.cal_s1 = CAL_N;
    nxt_st.cal_s2 = cur_ff.cal_s1;
    nxt_st.cal_prev = cur_ff.cal_s2;
    nxt_st.trg_s1 = SAMPLE_TRIGGER;
    nxt_st.trg_s2 = cur_ff.trg_s1;
    nxt_st.trg_prev = cur_ff.trg_s2;
    nxt_st.cal_reset = 1'b0;
    if (cur_ff.cnt != '0) begin
      nxt_st.cnt = cur_ff.cnt - 1'b1;
    end
    if (cal_fall) begin
      nxt_st.cal_reset = 1'b1;
      nxt_st.state = cal_seq_pkg::ST_IDLE;
      nxt_st.busy = 1'b0;
      nxt_st.pwron_run = 1'b0;
      nxt_st.cnt = '0;
    end else if (start && cur_ff.state == cal_seq_pkg::ST_IDLE) begin
      nxt_st.mode = sel_mode;
      nxt_st.pwron_run = cur_ff.pwron_pending;
      nxt_st.pwron_pending = 1'b0;
      nxt_st.busy = 1'b1;
      case (sel_mode)
        cal_seq_pkg::SELF_FULL, cal_seq_pkg::SYS_FULL: begin
          nxt_st.state = cal_seq_pkg::ST_DAC;
          nxt_st.cnt = CW'(DAC_CYCLES - 1);
        end
        cal_seq_pkg::SELF_OFFSET, cal_seq_pkg::SYS_OFFSET: begin
          nxt_st.state = cal_seq_pkg::ST_OFFSET;
          nxt_st.cnt = CW'(PHASE_CYCLES - 1);
        end
        default: begin
          nxt_st.state = cal_seq_pkg::ST_GAIN;
          nxt_st.cnt = CW'(PHASE_CYCLES - 1);
        end
      endcase
    end else begin
      case (cur_ff.state)
        cal_seq_pkg::ST_DAC: begin
          if (phase_end) begin
            nxt_st.state = cal_seq_pkg::ST_GAIN;
            nxt_st.cnt = CW'(PHASE_CYCLES - 1);
          end
        end
        cal_seq_pkg::ST_GAIN: begin
          if (phase_end) begin
            case (cur_ff.mode)
              cal_seq_pkg::SELF_FULL, cal_seq_pkg::SELF_GAIN_OFFSET: begin
                nxt_st.state = cal_seq_pkg::ST_OFFSET;
                nxt_st.cnt = CW'(PHASE_CYCLES - 1);
              end
              cal_seq_pkg::SYS_FULL, cal_seq_pkg::SYS_GAIN_OFFSET: begin
                nxt_st.state = cal_seq_pkg::ST_WAIT_TRIG;
                nxt_st.busy = 1'b0;
              end
              default: begin
                nxt_st.state = cal_seq_pkg::ST_IDLE;
                nxt_st.busy = 1'b0;
                nxt_st.pwron_run = 1'b0;
              end
            endcase
          end
        end
        cal_seq_pkg::ST_OFFSET: begin
          if (phase_end) begin
            nxt_st.state = cal_seq_pkg::ST_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.pwron_run = 1'b0;
          end
        end
        cal_seq_pkg::ST_WAIT_TRIG: begin
          if (trg_rise) begin
            nxt_st.state = cal_seq_pkg::ST_OFFSET;
            nxt_st.busy = 1'b1;
            nxt_st.cnt = CW'(PHASE_CYCLES - 1);
          end
        end
        default: begin
          nxt_st.state = cal_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      cur_ff <= '{cal_s1: cal_seq_pkg::PIN_IDLE, cal_s2: cal_seq_pkg::PIN_IDLE,
                  cal_prev: cal_seq_pkg::PIN_IDLE, trg_s1: 1'b0, trg_s2: 1'b0,
                  trg_prev: 1'b0, pwron_pending: 1'b1, pwron_run: 1'b0,
                  busy: 1'b0, cal_reset: 1'b0, mode: cal_seq_pkg::SELF_FULL,
                  state: cal_seq_pkg::ST_IDLE, cnt: '0};
    end else begin
      cur_ff <= nxt_st;
    end
  end
  // ==========================================
  // trims
  sat_trim #(
    .TW(cal_seq_pkg::TRIM_W),
    .EW(cal_seq_pkg::ERR_W),
    .LIM(cal_seq_pkg::OFFSET_LIM)
  ) u_offset_trim (
    .clk(CLK),
    .rst(RST),
    .apply(apply_off),
    .err(OFFSET_ERR),
    .trim(OFFSET_TRIM)
  );
  sat_trim #(
    .TW(cal_seq_pkg::TRIM_W),
    .EW(cal_seq_pkg::ERR_W),
    .LIM(cal_seq_pkg::GAIN_LIM)
  ) u_gain_trim (
    .clk(CLK),
    .rst(RST),
    .apply(apply_gain),
    .err(GAIN_ERR),
    .trim(GAIN_TRIM)
  );
  // ==========================================
  // outputs
  assign BUSY = cur_ff.busy;
  assign CAL_RESET = cur_ff.cal_reset;
  assign POWER_ON_CAL = cur_ff.pwron_run;
  assign DAC_TRIM_ACTIVE = cur_ff.state == cal_seq_pkg::ST_DAC;
  assign GAIN_TRIM_ACTIVE = cur_ff.state == cal_seq_pkg::ST_GAIN;
  assign OFFSET_TRIM_ACTIVE = cur_ff.state == cal_seq_pkg::ST_OFFSET;
  // ==========================================
  // checks
  chk_busy_on_start: assert property (@(posedge CLK) disable iff (RST)
    (start && cur_ff.state == cal_seq_pkg::ST_IDLE) |=> BUSY)
    else $error("busy did not rise after a start");
  chk_fall_resets: assert property (@(posedge CLK) disable iff (RST)
    cal_fall |=> CAL_RESET && !BUSY && cur_ff.state == cal_seq_pkg::ST_IDLE)
    else $error("pin fall did not reset the sequencer");
  chk_pwron_full: assert property (@(posedge CLK) disable iff (RST)
    (start && cur_ff.pwron_pending && cur_ff.state == cal_seq_pkg::ST_IDLE)
    |=> DAC_TRIM_ACTIVE && POWER_ON_CAL)
    else $error("power-on calibration did not begin with the dac phase");
  chk_go_skips_dac: assert property (@(posedge CLK) disable iff (RST)
    (start && !cur_ff.pwron_pending && cur_ff.state == cal_seq_pkg::ST_IDLE &&
     CAL_MODE == 3'h1) |=> GAIN_TRIM_ACTIVE ##0 !DAC_TRIM_ACTIVE)
    else $error("gain plus offset did not start with gain");
  chk_busy_in_phase: assert property (@(posedge CLK) disable iff (RST)
    (DAC_TRIM_ACTIVE || GAIN_TRIM_ACTIVE || OFFSET_TRIM_ACTIVE) |-> BUSY)
    else $error("busy low during a phase");
  chk_offset_bound: assert property (@(posedge CLK) disable iff (RST)
    OFFSET_TRIM <= $signed(cal_seq_pkg::TRIM_W'(cal_seq_pkg::OFFSET_LIM)) &&
    OFFSET_TRIM >= -$signed(cal_seq_pkg::TRIM_W'(cal_seq_pkg::OFFSET_LIM)))
    else $error("offset trim outside range");
  chk_gain_bound: assert property (@(posedge CLK) disable iff (RST)
    GAIN_TRIM <= $signed(cal_seq_pkg::TRIM_W'(cal_seq_pkg::GAIN_LIM)) &&
    GAIN_TRIM >= -$signed(cal_seq_pkg::TRIM_W'(cal_seq_pkg::GAIN_LIM)))
    else $error("gain trim outside range");
  chk_sys_wait: assert property (@(posedge CLK) disable iff (RST)
    (apply_gain && (cur_ff.mode == cal_seq_pkg::SYS_FULL ||
     cur_ff.mode == cal_seq_pkg::SYS_GAIN_OFFSET)) |=> !BUSY ##1 !BUSY)
    else $error("busy did not drop between system gain and offset");
  chk_phase_hold: assert property (@(posedge CLK) disable iff (RST)
    (GAIN_TRIM_ACTIVE && cur_ff.cnt != '0 && !cal_fall) |=> GAIN_TRIM_ACTIVE)
    else $error("gain phase ended before its count");
  chk_dac_to_gain: assert property (@(posedge CLK) disable iff (RST)
    (DAC_TRIM_ACTIVE && phase_end && !cal_fall) |=> GAIN_TRIM_ACTIVE && BUSY)
    else $error("dac phase did not hand over to gain");
  chk_offset_follows: assert property (@(posedge CLK) disable iff (RST)
    (apply_gain && (cur_ff.mode == cal_seq_pkg::SELF_FULL ||
     cur_ff.mode == cal_seq_pkg::SELF_GAIN_OFFSET)) |=> OFFSET_TRIM_ACTIVE && BUSY)
    else $error("self gain phase not followed by offset");
  chk_gain_only_ends: assert property (@(posedge CLK) disable iff (RST)
    (apply_gain && (cur_ff.mode == cal_seq_pkg::SELF_GAIN ||
     cur_ff.mode == cal_seq_pkg::SYS_GAIN))
    |=> !BUSY && cur_ff.state == cal_seq_pkg::ST_IDLE)
    else $error("gain only calibration did not end");
  chk_offset_ends: assert property (@(posedge CLK) disable iff (RST)
    apply_off |=> !BUSY && !POWER_ON_CAL && cur_ff.state == cal_seq_pkg::ST_IDLE)
    else $error("busy did not fall after the offset phase");
  chk_wait_not_busy: assert property (@(posedge CLK) disable iff (RST)
    (cur_ff.state == cal_seq_pkg::ST_WAIT_TRIG) |-> !BUSY && !OFFSET_TRIM_ACTIVE)
    else $error("busy high while waiting for the trigger");
  chk_trig_resumes: assert property (@(posedge CLK) disable iff (RST)
    (cur_ff.state == cal_seq_pkg::ST_WAIT_TRIG && trg_rise && !cal_fall)
    |=> OFFSET_TRIM_ACTIVE && BUSY)
    else $error("trigger did not start the system offset phase");
  chk_wait_holds: assert property (@(posedge CLK) disable iff (RST)
    (cur_ff.state == cal_seq_pkg::ST_WAIT_TRIG && !trg_rise && !cal_fall)
    |=> cur_ff.state == cal_seq_pkg::ST_WAIT_TRIG)
    else $error("left the trigger wait without a trigger");
  chk_start_ignored: assert property (@(posedge CLK) disable iff (RST)
    (start && BUSY && !phase_end) |=> BUSY && $stable(cur_ff.mode))
    else $error("a start was taken while busy");
  chk_trims_kept: assert property (@(posedge CLK) disable iff (RST)
    cal_fall |=> $stable(OFFSET_TRIM) && $stable(GAIN_TRIM))
    else $error("internal reset changed a trim");
  chk_pwron_busy: assert property (@(posedge CLK) disable iff (RST)
    POWER_ON_CAL |-> BUSY)
    else $error("power-on flag high while not busy");
  chk_count_down: assert property (@(posedge CLK) disable iff (RST)
    (BUSY && cur_ff.cnt != '0 && !cal_fall) |=> cur_ff.cnt == $past(cur_ff.cnt) - 1'b1)
    else $error("phase counter did not step down");
  chk_full_start: assert property (@(posedge CLK) disable iff (RST)
    (start && cur_ff.state == cal_seq_pkg::ST_IDLE &&
     (cur_ff.pwron_pending || CAL_MODE == 3'h0 || CAL_MODE == 3'h4)) |=> DAC_TRIM_ACTIVE)
    else $error("full calibration did not begin with the dac phase");
  chk_offset_start: assert property (@(posedge CLK) disable iff (RST)
    (start && !cur_ff.pwron_pending && cur_ff.state == cal_seq_pkg::ST_IDLE &&
     (CAL_MODE == 3'h2 || CAL_MODE == 3'h6)) |=> OFFSET_TRIM_ACTIVE && !GAIN_TRIM_ACTIVE)
    else $error("offset only calibration did not begin with offset");
  chk_gain_start: assert property (@(posedge CLK) disable iff (RST)
    (start && !cur_ff.pwron_pending && cur_ff.state == cal_seq_pkg::ST_IDLE &&
     (CAL_MODE == 3'h3 || CAL_MODE == 3'h5 || CAL_MODE == 3'h7)) |=> GAIN_TRIM_ACTIVE)
    else $error("gain first calibration did not begin with gain");
endmodule // cal_sequencer
`default_nettype wire

// ### testbench/cal_host.sv
// host-side model: drives the calibration pin and the sample trigger
`timescale 1ns/100ps
`default_nettype none
module cal_host (
  // clock
  input wire logic CLK,
  // pins to the device
  output var logic CAL_N,
  output var logic SAMPLE_TRIGGER
);
  // ==========================================
  // pin held low from power-on, as by the capacitor
  initial begin
    CAL_N = 1'b0;
    SAMPLE_TRIGGER = 1'b0;
  end
  // ==========================================
  // pin tasks, changed just after a rising edge
  task automatic cal_set(input logic v);
    @(posedge CLK);
    #1 CAL_N = v;
  endtask
  task automatic trig_set(input logic v);
    @(posedge CLK);
    #1 SAMPLE_TRIGGER = v;
  endtask
endmodule // cal_host
`default_nettype wire

// ### testbench/tb_adc_calibration_sequencer.sv
// self-checking bench of the calibration sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_adc_calibration_sequencer;
  localparam int D = 20;
  localparam int P = 8;
  typedef struct {
    logic [2:0] mode;
    int len;
    logic [2:0] stb;
    logic signed [15:0] ge;
    logic signed [15:0] oe;
    logic signed [11:0] eg;
    logic signed [11:0] eo;
  } row_t;
  logic CLK, RST, CAL_N, SAMPLE_TRIGGER, TRIM_START_BIT;
  logic [2:0] CAL_MODE;
  logic signed [cal_seq_pkg::ERR_W-1:0] OFFSET_ERR, GAIN_ERR;
  logic BUSY, CAL_RESET, POWER_ON_CAL, DAC_TRIM_ACTIVE, GAIN_TRIM_ACTIVE, OFFSET_TRIM_ACTIVE;
  logic signed [cal_seq_pkg::TRIM_W-1:0] OFFSET_TRIM, GAIN_TRIM;
  int mismatches = 0;
  int checks_done = 0;
  row_t rows [8];
  int n;
  int i;
  // ==========================================
  // design, host model and clock
  cal_sequencer #(.DAC_CYCLES(D), .PHASE_CYCLES(P)) dut (.CLK(CLK), .RST(RST), .CAL_N(CAL_N),
    .SAMPLE_TRIGGER(SAMPLE_TRIGGER), .TRIM_START_BIT(TRIM_START_BIT), .CAL_MODE(CAL_MODE),
    .OFFSET_ERR(OFFSET_ERR), .GAIN_ERR(GAIN_ERR), .BUSY(BUSY), .CAL_RESET(CAL_RESET),
    .POWER_ON_CAL(POWER_ON_CAL), .DAC_TRIM_ACTIVE(DAC_TRIM_ACTIVE),
    .GAIN_TRIM_ACTIVE(GAIN_TRIM_ACTIVE), .OFFSET_TRIM_ACTIVE(OFFSET_TRIM_ACTIVE),
    .OFFSET_TRIM(OFFSET_TRIM), .GAIN_TRIM(GAIN_TRIM));
  cal_host host (.CLK(CLK), .CAL_N(CAL_N), .SAMPLE_TRIGGER(SAMPLE_TRIGGER));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // ==========================================
  // helpers
  task automatic step();
    @(posedge CLK);
    #1;
  endtask
  task automatic complete_run();
    $display("TB: checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    mismatches++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic check_flags(input logic [2:0] got, input logic [2:0] exp, input string what);
    checks_done++;
    if (got !== exp) fail(what);
  endtask
  task automatic check_len(input int got, input int exp);
    checks_done++;
    if (got != exp) fail("busy length");
  endtask
  task automatic check_trim(input logic signed [11:0] got, input logic signed [11:0] exp);
    checks_done++;
    if (got !== exp) fail("trim value");
  endtask
  task automatic sw_start(input logic [2:0] m);
    TRIM_START_BIT = 1'b1;
    CAL_MODE = m;
    step();
    TRIM_START_BIT = 1'b0;
  endtask
  task automatic wait_busy();
    int k;
    for (k = 0; k < 10 && BUSY !== 1'b1; k++) step();
    if (BUSY !== 1'b1) begin
      fail("busy never rose");
      complete_run();
    end
  endtask
  task automatic busy_len(output int c);
    c = 0;
    while (BUSY === 1'b1 && c < 200) begin
      c++;
      step();
    end
    if (c >= 200) begin
      fail("busy never fell");
      complete_run();
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    RST = 1'b1;
    TRIM_START_BIT = 1'b0;
    CAL_MODE = 3'h3;
    OFFSET_ERR = 16'sh0000;
    GAIN_ERR = 16'sh0000;
    rows[0] = '{3'h3, P, 3'h2, 16'sh000a, 16'sh0000, -12'sh00a, 12'sh000};
    rows[1] = '{3'h2, P, 3'h1, 16'sh0000, -16'sh0014, -12'sh00a, 12'sh014};
    rows[2] = '{3'h1, 2 * P, 3'h2, -16'sh0005, 16'sh0258, -12'sh005, -12'sh244};
    rows[3] = '{3'h0, D + 2 * P, 3'h4, 16'sh03e8, 16'sh0064, -12'sh133, -12'sh266};
    rows[4] = '{3'h6, P, 3'h1, 16'sh0000, -16'sh07d0, -12'sh133, 12'sh266};
    rows[5] = '{3'h7, P, 3'h2, -16'sh0190, 16'sh0000, 12'sh05d, 12'sh266};
    rows[6] = '{3'h6, P, 3'h1, 16'sh0000, 16'sh0000, 12'sh05d, 12'sh266};
    rows[7] = '{3'h7, P, 3'h2, 16'sh0000, 16'sh0000, 12'sh05d, 12'sh266};
    repeat (2) @(posedge CLK);
    #1 RST = 1'b0;
    check_flags({2'b00, BUSY}, 3'h0, "busy after reset");
    check_trim(OFFSET_TRIM, cal_seq_pkg::TRIM_RST);
    $display("test reset done");
    host.cal_set(1'b1);
    wait_busy();
    check_flags({2'b00, POWER_ON_CAL}, 3'h1, "power-on flag");
    check_flags({DAC_TRIM_ACTIVE, GAIN_TRIM_ACTIVE, OFFSET_TRIM_ACTIVE}, 3'h4, "dac first");
    busy_len(n);
    check_len(n, D + 2 * P);
    check_flags({2'b00, POWER_ON_CAL}, 3'h0, "power-on flag cleared");
    $display("test power-on done");
    for (i = 0; i < 8; i++) begin
      GAIN_ERR = rows[i].ge;
      OFFSET_ERR = rows[i].oe;
      sw_start(rows[i].mode);
      check_flags({2'b00, BUSY}, 3'h1, "busy at start");
      check_flags({DAC_TRIM_ACTIVE, GAIN_TRIM_ACTIVE, OFFSET_TRIM_ACTIVE},
        rows[i].stb, "phase");
      busy_len(n);
      check_len(n, rows[i].len);
      check_trim(GAIN_TRIM, rows[i].eg);
      check_trim(OFFSET_TRIM, rows[i].eo);
      $display("test row %0d done", i);
    end
    GAIN_ERR = 16'sh0000;
    OFFSET_ERR = 16'sh0000;
    sw_start(3'h3);
    repeat (2) step();
    sw_start(3'h0);
    busy_len(n);
    check_len(n, P - 3);
    $display("test refused start done");
    sw_start(3'h0);
    repeat (5) step();
    host.cal_set(1'b0);
    for (i = 0; i < 8 && CAL_RESET !== 1'b1; i++) step();
    check_flags({2'b00, CAL_RESET}, 3'h1, "internal reset pulse");
    if (CAL_RESET !== 1'b1) begin
      complete_run();
    end
    step();
    check_flags({2'b00, BUSY}, 3'h0, "busy after abort");
    check_trim(GAIN_TRIM, 12'sh05d);
    CAL_MODE = 3'h2;
    host.cal_set(1'b1);
    wait_busy();
    busy_len(n);
    check_len(n, P);
    $display("test pin abort done");
    for (i = 0; i < 4; i++) begin
      sw_start(i == 0 ? 3'h4 : 3'h5);
      busy_len(n);
      check_len(n, i == 0 ? D + P : P);
      repeat (6) step();
      check_flags({2'b00, BUSY}, 3'h0, "waits for trigger");
      host.trig_set(1'b1);
      wait_busy();
      check_flags({DAC_TRIM_ACTIVE, GAIN_TRIM_ACTIVE, OFFSET_TRIM_ACTIVE},
        3'h1, "offset last");
      busy_len(n);
      check_len(n, P);
      host.trig_set(1'b0);
      $display("test system run %0d done", i);
    end
    complete_run();
  end
endmodule // tb_adc_calibration_sequencer
`default_nettype wire
